// File: design/scra_pkg.sv
package scra_pkg;
	// ==========================================
	// Widths and counts
	localparam int WORD_W = 16;
	localparam int NUM_REGS = 16;
	localparam int NUM_PORTS = 16;
	localparam int NUM_MREGS = 11;
	localparam int SYS_CLK_MHZ = 200;
	// Power-on hold-off in microseconds
	localparam int POR_HOLD_US = 250;
	localparam int POR_HOLD_CYC = POR_HOLD_US * SYS_CLK_MHZ;
	localparam int CONV_CYC = 64;
	// ==========================================
	// Software bus map (word index)
	localparam logic [7:0] ADR_PORT_LAST = 8'h0F;
	localparam logic [7:0] ADR_DBG_ACC = 8'h10;
	localparam logic [7:0] ADR_DBG_PTR = 8'h11;
	localparam logic [7:0] ADR_DBG_INS = 8'h12;
	localparam logic [7:0] ADR_STATUS = 8'h13;
	localparam logic [7:0] ADR_CTRL = 8'h14;
	// Control bits: halt request, single step pulse
	localparam int CTRL_HALT = 0;
	localparam int CTRL_STEP = 1;
	// ==========================================
	// Processor register roles
	localparam logic [3:0] REG_ACC = 4'h0;
	localparam logic [3:0] REG_PTR = 4'h1;
	localparam int NUM_FIXED = 5;
	// Ports used for module access
	localparam logic [3:0] PORT_MADDR = 4'hD;
	localparam logic [3:0] PORT_MDATA = 4'hE;
	localparam logic [3:0] PORT_MCMD = 4'hF;
	// Instruction opcodes [15:12]
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_LDI = 4'h1, OP_TO_REG = 4'h2, OP_FROM_REG = 4'h3,
		OP_PORT_READ = 4'h4, OP_PORT_WRITE = 4'h5
	} scra_op_t;
	// ==========================================
	// Converter module register indices
	localparam logic [3:0] MR_CFG1A = 4'h0;
	localparam logic [3:0] MR_CFGTB = 4'h5;
	localparam logic [3:0] MR_DATA1 = 4'h6;
	localparam logic [3:0] MR_DATA2 = 4'h7;
	localparam logic [3:0] MR_DATAT = 4'h8;
	localparam logic [3:0] MR_CTRL = 4'h9;
	localparam logic [3:0] MR_POWER = 4'hA;
	// Control fields
	localparam int CV_CH1 = 0;
	localparam int CV_CH2 = 1;
	localparam int CV_TEMP = 2;
	localparam int SE_LSB = 4;
	// Config A: resolution [2:0], gain [7:4]; config B: ref [1:0], offset [15:8]
	localparam int RES_W = 3;
	localparam int RES_MIN = 9;
	localparam int GAIN_LSB = 4;
	localparam int OFS_LSB = 8;
	// Reference selections
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_EXT = 2'h1;
	localparam logic [1:0] REF_QUAD_BG = 2'h2;
	localparam logic [1:0] REF_BANDGAP = 2'h3;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} scra_bus_req_t;
	typedef struct packed {
		logic [1:0] chan;
		logic [3:0] se_sel;
		logic [1:0] ref_sel;
		logic [3:0] gain;
		logic [7:0] offset;
		logic busy;
	} scra_afe_t;
endpackage

// File: design/scra_core.sv
// Contract
// - Hold processor in reset 250us after power-on.
// - Reset forces all processor registers to defaults.
// - Reset clears every module power enable.
// - Sixteen 16-bit processor registers.
// - Five fixed-role registers, eleven general purpose.
// - Acc, pointer, instruction readable only when halted.
// - Sixteen 16-bit ports, host read/write.
// - Only port read/write instructions touch ports.
// - Three ports form indirect module access path.
// - Control register write launches conversion.
// - Data registers hold conversion results.
// - Resolution selectable nine to sixteen bits.
// - Result is 16-bit two's complement word.
// - Temperature result 15 bits plus sign; code keeps the top 9..16 bits per its config A, like the other channels.
// - Temperature conversion forces bandgap reference.
// - Other channels select supply, external, quadrupled bandgap.
// - Temperature path no gain, offset still applies.
// - Ten converter registers, three channels.
// - Two configuration registers per channel.
// - Completed result goes to channel's result register.
// - Control selects channel and single-ended input.
// - Multiplexer offers fifteen internal single-ended nodes.
// - Convert bit halts processor; bits clear at end.
module scra_core
	import scra_pkg::*;
#(
	parameter int POR_CYCLES = POR_HOLD_CYC,
	parameter int CONV_CYCLES = CONV_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire scra_pkg::scra_bus_req_t bus_req,
	output logic [15:0] bus_rdata,
	output logic [15:0] instr_addr,
	input wire logic [15:0] instr_data,
	output logic instr_fetch,
	input wire logic [15:0] adc_sample,
	output scra_pkg::scra_afe_t afe_ctrl,
	output logic [15:0] power_en
);
	import scra_pkg::*;

	// ==========================================
	// State
	typedef enum {ST_POR, ST_RUN, ST_CONV} scra_state_t;
	scra_state_t state_reg, state_next;
	logic [15:0] por_cnt_reg, por_cnt_next; // Hold-off counter
	logic [15:0] conv_cnt_reg, conv_cnt_next; // Conversion timer
	logic [15:0] regs_reg [NUM_REGS]; // Processor registers
	logic [15:0] regs_next [NUM_REGS];
	logic [15:0] ports_reg [NUM_PORTS]; // Processor ports
	logic [15:0] ports_next [NUM_PORTS];
	logic [15:0] mregs_reg [NUM_MREGS]; // Converter and power registers
	logic [15:0] mregs_next [NUM_MREGS];
	logic [15:0] pc_reg, pc_next; // Fetch address
	logic [15:0] ir_reg, ir_next; // Last executed instruction
	logic [1:0] ctrl_reg, ctrl_next; // Halt and step
	logic [15:0] rdata_reg, rdata_next;
	logic halted; // Processor not executing
	logic execute; // Instruction retired this cycle
	logic [1:0] cur_chan; // Channel being converted
	logic [15:0] res_mask; // Kept result bits

	// Processor stands still in hold-off, conversion, or debug halt
	assign halted = (state_reg != ST_RUN) || ctrl_reg[CTRL_HALT];
	assign execute = (state_reg == ST_RUN) && (!ctrl_reg[CTRL_HALT] || ctrl_reg[CTRL_STEP]);
	assign instr_fetch = execute;
	assign instr_addr = pc_reg;
	assign bus_rdata = rdata_reg;
	assign power_en = mregs_reg[MR_POWER];

	// ==========================================
	// Converter front-end steering
	always_comb begin
		// Channel priority one, two, temperature
		if (mregs_reg[MR_CTRL][CV_CH1]) begin
			cur_chan = 2'h0;
		end else if (mregs_reg[MR_CTRL][CV_CH2]) begin
			cur_chan = 2'h1;
		end else begin
			cur_chan = 2'h2;
		end
		afe_ctrl.chan = cur_chan;
		afe_ctrl.se_sel = mregs_reg[MR_CTRL][SE_LSB +: 4];
		afe_ctrl.busy = (state_reg == ST_CONV);
		// Offset from config B of the channel, temperature too
		afe_ctrl.offset = mregs_reg[{cur_chan, 1'b1}][OFS_LSB +: 8];
		if (cur_chan == 2'h2) begin
			afe_ctrl.ref_sel = REF_BANDGAP;
			afe_ctrl.gain = 4'h0;
		end else begin
			// Bandgap code not selectable for these channels
			afe_ctrl.ref_sel = (mregs_reg[{cur_chan, 1'b1}][1:0] == REF_BANDGAP) ?
				REF_QUAD_BG : mregs_reg[{cur_chan, 1'b1}][1:0];
			afe_ctrl.gain = mregs_reg[{cur_chan, 1'b0}][GAIN_LSB +: 4];
		end
		// Keep the top 9..16 bits of the result
		res_mask = 16'hFFFF << (3'(7) - mregs_reg[{cur_chan, 1'b0}][RES_W-1:0]);
	end

	// ==========================================
	// Next-state logic
	always_comb begin
		logic [3:0] op;
		logic [3:0] idx;
		logic [3:0] midx;
		op = instr_data[15:12];
		idx = instr_data[11:8];
		midx = ports_reg[PORT_MADDR][3:0];
		state_next = state_reg;
		por_cnt_next = por_cnt_reg;
		conv_cnt_next = conv_cnt_reg;
		regs_next = regs_reg;
		ports_next = ports_reg;
		mregs_next = mregs_reg;
		pc_next = pc_reg;
		ir_next = ir_reg;
		ctrl_next = ctrl_reg;
		ctrl_next[CTRL_STEP] = 1'b0;
		rdata_next = 16'h0000;
		unique case (state_reg)
			ST_POR: begin
				// Count out the hold-off before first fetch
				if (por_cnt_reg == 16'(POR_CYCLES - 1)) begin
					state_next = ST_RUN;
				end else begin
					por_cnt_next = por_cnt_reg + 16'h0001;
				end
			end
			ST_RUN: begin
				if (execute) begin
					pc_next = pc_reg + 16'h0001;
					ir_next = instr_data;
					unique case (op)
						OP_LDI: begin
							regs_next[REG_ACC] = {8'h00, instr_data[7:0]};
						end
						OP_TO_REG: begin
							regs_next[idx] = regs_reg[REG_ACC];
						end
						OP_FROM_REG: begin
							regs_next[REG_ACC] = regs_reg[idx];
						end
						OP_PORT_READ: begin
							regs_next[REG_ACC] = ports_reg[idx];
						end
						OP_PORT_WRITE: begin
							ports_next[idx] = regs_reg[REG_ACC];
							// Command port write runs a module access
							if (idx == PORT_MCMD) begin
								if (regs_reg[REG_ACC][0]) begin
									// Result registers are not writable
									if (midx < MR_DATA1 || midx == MR_CTRL || midx == MR_POWER) begin
										mregs_next[midx] = ports_reg[PORT_MDATA];
									end
									if (midx == MR_CTRL && ports_reg[PORT_MDATA][CV_TEMP:CV_CH1] != 3'h0) begin
										state_next = ST_CONV;
										conv_cnt_next = 16'h0000;
									end
								end else begin
									ports_next[PORT_MDATA] = (midx < 4'(NUM_MREGS)) ?
										mregs_reg[midx] : 16'h0000;
								end
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_CONV: begin
				// Processor and fetch stay stopped here
				if (conv_cnt_reg == 16'(CONV_CYCLES - 1)) begin
					mregs_next[MR_DATA1 + 4'(cur_chan)] = adc_sample & res_mask;
					mregs_next[MR_CTRL][CV_TEMP:CV_CH1] = 3'h0;
					state_next = ST_RUN;
				end else begin
					conv_cnt_next = conv_cnt_reg + 16'h0001;
				end
			end
		endcase
		// Host port access wins over a same-cycle port write
		if (bus_req.wr) begin
			if (bus_req.addr <= ADR_PORT_LAST) begin
				ports_next[bus_req.addr[3:0]] = bus_req.wdata;
			end else if (bus_req.addr == ADR_CTRL) begin
				ctrl_next[CTRL_HALT] = bus_req.wdata[CTRL_HALT];
				ctrl_next[CTRL_STEP] = bus_req.wdata[CTRL_STEP] & ctrl_reg[CTRL_HALT];
			end
		end
		if (bus_req.rd) begin
			if (bus_req.addr <= ADR_PORT_LAST) begin
				rdata_next = ports_reg[bus_req.addr[3:0]];
			end else if (bus_req.addr == ADR_DBG_ACC) begin
				rdata_next = halted ? regs_reg[REG_ACC] : 16'h0000;
			end else if (bus_req.addr == ADR_DBG_PTR) begin
				rdata_next = halted ? regs_reg[REG_PTR] : 16'h0000;
			end else if (bus_req.addr == ADR_DBG_INS) begin
				rdata_next = halted ? ir_reg : 16'h0000;
			end else if (bus_req.addr == ADR_STATUS) begin
				rdata_next = {13'h0000, state_reg == ST_CONV, state_reg == ST_POR, halted};
			end else if (bus_req.addr == ADR_CTRL) begin
				rdata_next = {15'h0000, ctrl_reg[CTRL_HALT]};
			end
		end
	end

	// ==========================================
	// Registers; power-on reset clears everything
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_POR;
			por_cnt_reg <= 16'h0000;
			conv_cnt_reg <= 16'h0000;
			pc_reg <= 16'h0000;
			ir_reg <= 16'h0000;
			ctrl_reg <= 2'h0;
			rdata_reg <= 16'h0000;
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_reg[i] <= 16'h0000;
			end
			for (int i = 0; i < NUM_PORTS; i++) begin
				ports_reg[i] <= 16'h0000;
			end
			for (int i = 0; i < NUM_MREGS; i++) begin
				mregs_reg[i] <= 16'h0000;
			end
		end else begin
			state_reg <= state_next;
			por_cnt_reg <= por_cnt_next;
			conv_cnt_reg <= conv_cnt_next;
			pc_reg <= pc_next;
			ir_reg <= ir_next;
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
			regs_reg <= regs_next;
			ports_reg <= ports_next;
			mregs_reg <= mregs_next;
		end
	end
endmodule

// File: tb/scra_flash.sv
// ==========================================
// Program store model feeding the fetch port
module scra_flash (
	input wire logic [15:0] instr_addr,
	output logic [15:0] instr_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rom [0:63]; // Bench loads the program here
	// Past the end the store reads as no-operation
	assign instr_data = (instr_addr < 16'h0040) ? rom[instr_addr[5:0]] : 16'h0000;
endmodule

// File: tb/scra_core_monitor.sv
// ==========================================
// Port-level checker for the processor core
module scra_core_monitor
	import scra_pkg::*;
#(
	parameter int POR_CYCLES = 20,
	parameter int CONV_CYCLES = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire scra_pkg::scra_bus_req_t bus_req,
	input wire logic [15:0] bus_rdata,
	input wire logic [15:0] instr_addr,
	input wire logic [15:0] instr_data,
	input wire logic instr_fetch,
	input wire logic [15:0] adc_sample,
	input wire scra_pkg::scra_afe_t afe_ctrl,
	input wire logic [15:0] power_en
);
	timeunit 1ns;
	timeprecision 100ps;
	// Busy stands CONV_CYCLES cycles; the window counts from the fourth busy cycle
	localparam int CONV_LO = CONV_CYCLES - 4; // Earliest end of a conversion
	localparam int CONV_HI = CONV_CYCLES - 2; // Latest end of a conversion
	logic [31:0] por_cnt_reg, por_cnt_next; // Cycles since reset release
	// Saturating count of the hold-off
	always_comb begin
		por_cnt_next = (por_cnt_reg >= 32'(POR_CYCLES)) ? por_cnt_reg : por_cnt_reg + 32'h1;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			por_cnt_reg <= 32'h0;
		end else begin
			por_cnt_reg <= por_cnt_next;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_por_hold: assert property ((por_cnt_reg < 32'(POR_CYCLES - 1)) |-> !instr_fetch && instr_addr == 16'h0000)
		else $error("fetch during hold-off");
	a_reset_clear: assert property ($fell(rst) |-> power_en == 16'h0000 && instr_addr == 16'h0000)
		else $error("state not cleared by reset");
	a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
		else $error("read data without read");
	a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > ADR_CTRL |=> bus_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_port_echo: assert property (bus_req.wr && bus_req.addr <= ADR_PORT_LAST ##1
		bus_req.rd && bus_req.addr == $past(bus_req.addr) |=> bus_rdata == $past(bus_req.wdata, 2))
		else $error("port lost host write");
	a_conv_stall: assert property (afe_ctrl.busy |-> !instr_fetch)
		else $error("fetch during conversion");
	a_conv_span: assert property ($rose(afe_ctrl.busy) |-> afe_ctrl.busy [*4] ##[CONV_LO:CONV_HI] !afe_ctrl.busy)
		else $error("conversion length wrong");
	a_temp_ref: assert property (afe_ctrl.chan == 2'h2 |-> afe_ctrl.ref_sel == REF_BANDGAP && afe_ctrl.gain == 4'h0)
		else $error("temperature reference or gain wrong");
	a_diff_ref: assert property (afe_ctrl.chan != 2'h2 |-> afe_ctrl.ref_sel != REF_BANDGAP)
		else $error("bandgap on differential channel");
	c_temp_conv: cover property ($rose(afe_ctrl.busy) && afe_ctrl.chan == 2'h2);
	c_run_start: cover property ($rose(instr_fetch));
	c_halt_write: cover property (bus_req.wr && bus_req.addr == ADR_CTRL);
endmodule
bind scra_core scra_core_monitor #(.POR_CYCLES(POR_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_mon (
	.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .instr_addr(instr_addr),
	.instr_data(instr_data), .instr_fetch(instr_fetch), .adc_sample(adc_sample), .afe_ctrl(afe_ctrl),
	.power_en(power_en));

// File: tb/sensor_cpu_register_access_tb.sv
// ==========================================
// Bench: program run, conversions, debug reads, port traffic
module sensor_cpu_register_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import scra_pkg::*;
	logic sys_clk, rst, instr_fetch, rd_d;
	scra_bus_req_t bus_req; // Host bus request
	scra_afe_t afe_ctrl;
	logic [15:0] bus_rdata, instr_addr, instr_data, adc_sample, power_en, samp, val;
	logic [15:0] exp_q [$]; // Expected read data, oldest first
	int bad_count, tests_run, cycles, pc;
	integer seed;
	scra_core #(.POR_CYCLES(20), .CONV_CYCLES(8)) DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .instr_addr(instr_addr), .instr_data(instr_data), .instr_fetch(instr_fetch),
		.adc_sample(adc_sample), .afe_ctrl(afe_ctrl), .power_en(power_en));
	scra_flash flash (.instr_addr(instr_addr), .instr_data(instr_data));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic test_done;
		if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus cycles, one strobe per clock
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		exp_q.push_back(e);
	endtask
	// Program building
	task automatic emit(input logic [3:0] op, input logic [3:0] idx, input logic [7:0] imm);
		flash.rom[pc] = {op, idx, imm};
		pc++;
	endtask
	task automatic mw(input logic [7:0] r, input logic [7:0] v);
		emit(OP_LDI, 4'h0, r);
		emit(OP_PORT_WRITE, PORT_MADDR, 8'h00);
		emit(OP_LDI, 4'h0, v);
		emit(OP_PORT_WRITE, PORT_MDATA, 8'h00);
		emit(OP_LDI, 4'h0, 8'h01);
		emit(OP_PORT_WRITE, PORT_MCMD, 8'h00);
	endtask
	task automatic rb(input logic [7:0] r, input logic [3:0] p);
		emit(OP_LDI, 4'h0, r);
		emit(OP_PORT_WRITE, PORT_MADDR, 8'h00);
		emit(OP_LDI, 4'h0, 8'h00);
		emit(OP_PORT_WRITE, PORT_MCMD, 8'h00);
		emit(OP_PORT_READ, PORT_MDATA, 8'h00);
		emit(OP_PORT_WRITE, p, 8'h00);
	endtask
	// Read data watcher and hang guard
	always @(posedge sys_clk) begin
		rd_d <= bus_req.rd;
		cycles <= cycles + 1;
		if (rd_d === 1'b1) begin
			chk("bus_rdata", exp_q.pop_front(), bus_rdata);
		end
		if (cycles > 3000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		seed = 32'h61d25830;
		rst = 1'b1;
		bus_req = '0;
		adc_sample = 16'h0000;
		rd_d = 1'b0;
		cycles = 0;
		bad_count = 0;
		tests_run = 0;
		pc = 0;
		@(posedge sys_clk);
		for (int i = 0; i < 64; i++) flash.rom[i] = 16'h0000;
		mw(8'h0A, 8'h3C);
		mw(8'h01, 8'h03);
		mw(8'h02, 8'h07);
		mw(8'h09, 8'h01);
		rb(8'h06, 4'h1);
		mw(8'h09, 8'h02);
		rb(8'h07, 4'h2);
		mw(8'h09, 8'h04);
		rb(8'h08, 4'h3);
		emit(OP_LDI, 4'h0, 8'h5A);
		emit(OP_TO_REG, 4'h1, 8'h00);
		emit(OP_TO_REG, 4'hF, 8'h00);
		emit(OP_LDI, 4'h0, 8'h00);
		emit(OP_FROM_REG, 4'hF, 8'h00);
		samp = $random(seed);
		adc_sample <= samp;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		chk("power_en", 16'h0000, power_en);
		bus_rd(ADR_DBG_ACC, 16'h0000);
		bus_rd(8'h20, 16'h0000);
		@(posedge sys_clk);
		bus_req <= '0;
		while (instr_addr < 16'h003E) @(posedge sys_clk);
		chk("power_en", 16'h003C, power_en);
		bus_rd(ADR_DBG_ACC, 16'h0000);
		bus_rd(8'h01, samp & 16'hFF80);
		bus_rd(8'h02, samp);
		bus_rd(8'h03, samp & 16'hFF80);
		bus_wr(ADR_CTRL, 16'h0001);
		bus_rd(ADR_DBG_ACC, 16'h005A);
		bus_rd(ADR_DBG_PTR, 16'h005A);
		bus_rd(ADR_DBG_INS, 16'h0000);
		bus_rd(ADR_STATUS, 16'h0001);
		// Single step while halted moves the fetch address by one
		pc = instr_addr;
		bus_wr(ADR_CTRL, 16'h0003);
		@(posedge sys_clk);
		bus_req <= '0;
		repeat (2) @(posedge sys_clk);
		chk("instr_addr", 16'(pc + 1), instr_addr);
		bus_rd(ADR_CTRL, 16'h0001);
		for (int i = 0; i < 16; i++) begin
			val = $random(seed);
			bus_wr(8'(i), val);
			bus_rd(8'(i), val);
		end
		@(posedge sys_clk);
		bus_req <= '0;
		repeat (3) @(posedge sys_clk);
		test_done();
	end
endmodule
